// >>> hdl/mch_regs.svh
// Register offsets, field positions, reset values and timing counts of the modem port
// Functional notes
// [RULE1] Request-to-send stays on while powered, except in line-control mode.
// [RULE2] In line-control mode request-to-send follows transmit state, off in receive state.
// [RULE3] No character starts while clear-to-send is off; modem raises it to permit sending.
// [RULE4] In remote mode nothing is received while data-set-ready is off.
// [RULE5] Reception runs only while carrier detect is on.
// [RULE6] In remote mode data-terminal-ready is on unless another condition forces it off.
// [RULE7] Printer-ready option drops data-terminal-ready on error or nearly full buffer; the code applies it only outside line-control mode.
// [RULE8] Each modem control input reads inactive when modem or cable is absent.
// [RULE9] Transmitted data idles at mark; zero bit is space, one bit is mark.
// [RULE10] Modem holds received data at mark between characters, zero space, one mark.
// [RULE11] Reverse-channel data goes out on the secondary transmit line.
// [RULE12] Reverse-channel data arrives on the secondary receive line, apart from main data.
// [RULE13] Character: start bit, seven data bits LSB first, parity bit, stop bit.
// [RULE14] Parity off skips receive check; transmit parity still follows odd/even choice.
// [RULE15] Modem control inputs are synchronised before they gate sending or receiving.
`ifndef MCH_REGS_SVH
`define MCH_REGS_SVH

`define MCH_OFS_CTRL 8'h00
`define MCH_OFS_STAT 8'h04
`define MCH_OFS_TXD 8'h08
`define MCH_OFS_RXD 8'h0C
`define MCH_OFS_BAUD 8'h10

`define MCH_C_LINE_CTL 0
`define MCH_C_XMIT 1
`define MCH_C_REMOTE 2
`define MCH_C_PRDY_OPT 3
`define MCH_C_ERR 4
`define MCH_C_NEAR_FULL 5
`define MCH_C_PAR_EN 6
`define MCH_C_ODD 7
`define MCH_C_SEC_TX 8
`define MCH_CTRL_W 9
`define MCH_CTRL_RST 9'h104

`define MCH_S_CTS 0
`define MCH_S_DSR 1
`define MCH_S_DCD 2
`define MCH_S_RTS 3
`define MCH_S_DTR 4
`define MCH_S_RXV 5
`define MCH_S_PERR 6
`define MCH_S_OVR 7
`define MCH_S_SEC_RX 8
`define MCH_S_TX_BUSY 9
`define MCH_S_Q_EMPTY 10
`define MCH_S_Q_FULL 11

`define MCH_RXD_VALID 8

`define MCH_CLK_HZ 40000000
`define MCH_BAUD_DEF 300
`define MCH_DIV_DEF (`MCH_CLK_HZ / `MCH_BAUD_DEF)

`define MCH_RESP_OK 2'h0
`define MCH_RESP_SLVERR 2'h2

`endif

// >>> hdl/mch_pkg.sv
// Types shared by the modem port modules
package mch_pkg;
  typedef logic [6:0] mch_char_t;
  typedef logic [31:0] mch_word_t;
  typedef enum logic [1:0] {MCH_RX_IDLE, MCH_RX_START, MCH_RX_BITS, MCH_RX_STOP} mch_rx_state_e;
  typedef enum logic [1:0] {MCH_TX_IDLE, MCH_TX_SHIFT} mch_tx_state_e;
endpackage

// >>> hdl/mch_stream_if.sv
// Valid/ready carrier between the queue and the serialiser
`timescale 1ns/1ps
`default_nettype none
interface mch_stream_if #(parameter int W = 7);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> hdl/mch_fifo.sv
// Transmit character queue with parameter width and depth
`timescale 1ns/1ps
`default_nettype none
module mch_fifo #(
  parameter int W = 7,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  mch_stream_if.snk fill,
  mch_stream_if.src drain,
  output logic full
);
  import mch_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr_r;
  logic [AW:0] rptr_r;
  logic empty;
  logic push;
  logic pop;

  assign empty = (wptr_r == rptr_r);
  assign full = (wptr_r[AW-1:0] == rptr_r[AW-1:0]) && (wptr_r[AW] != rptr_r[AW]);
  assign fill.ready = ~full;
  assign drain.valid = ~empty;
  assign drain.data = mem[rptr_r[AW-1:0]];
  assign push = fill.valid & ~full;
  assign pop = drain.ready & ~empty;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wptr_r[AW-1:0]] <= fill.data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_r <= '0;
    end else if (push) begin
      wptr_r <= wptr_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rptr_r <= '0;
    end else if (pop) begin
      rptr_r <= rptr_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/mch_uart_tx.sv
// Character serialiser: start, seven data bits, parity, stop
`timescale 1ns/1ps
`default_nettype none
`include "mch_regs.svh"
module mch_uart_tx #(
  parameter int DIV_W = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [DIV_W-1:0] bit_div,
  input wire logic odd_par,
  input wire logic send_ok,
  mch_stream_if.snk chr,
  output logic txd,
  output logic busy
);
  import mch_pkg::*;
  mch_tx_state_e st_r;
  logic [9:0] sh_r;
  logic [3:0] nbits_r;
  logic [DIV_W-1:0] cnt_r;
  logic take;
  logic par;

  assign take = (st_r == MCH_TX_IDLE) & chr.valid & send_ok; // [RULE3]
  assign chr.ready = (st_r == MCH_TX_IDLE) & send_ok;
  assign par = odd_par ? ~(^chr.data) : ^chr.data; // [RULE14]
  assign busy = (st_r != MCH_TX_IDLE);

  // Clear-to-send is looked at only between characters; a started frame always completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= MCH_TX_IDLE;
      sh_r <= '1;
      nbits_r <= '0;
      cnt_r <= '0;
      txd <= 1'b1;
    end else begin
      case (st_r)
        MCH_TX_IDLE: begin
          txd <= 1'b1; // [RULE9]
          if (take) begin
            sh_r <= {1'b1, par, chr.data, 1'b0}; // [RULE13]
            nbits_r <= 4'd10;
            cnt_r <= '0;
            st_r <= MCH_TX_SHIFT;
          end
        end
        MCH_TX_SHIFT: begin
          if (cnt_r == '0) begin
            if (nbits_r == 4'd0) begin
              st_r <= MCH_TX_IDLE;
              txd <= 1'b1;
            end else begin
              txd <= sh_r[0]; // [RULE9]
              sh_r <= {1'b1, sh_r[9:1]};
              nbits_r <= nbits_r - 4'd1;
              cnt_r <= bit_div - 1'b1;
            end
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          st_r <= MCH_TX_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> hdl/mch_top.sv
// Modem port: control lines, serial data path and AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "mch_regs.svh"
module mch_top #(
  parameter int ADDR_W = 8,
  parameter int DIV_W = 20,
  parameter int QDEPTH = 16,
  parameter logic [DIV_W-1:0] BAUD_DIV = DIV_W'(`MCH_DIV_DEF)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire mch_pkg::mch_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output mch_pkg::mch_word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic txd,
  input wire logic rxd,
  output logic rts,
  input wire logic cts,
  input wire logic dsr,
  output logic dtr,
  input wire logic dcd,
  output logic sec_txd,
  input wire logic sec_rxd
);
  import mch_pkg::*;

  // Two-stage synchronisers; control lines reset to off so an absent modem reads inactive, data lines to mark
  logic [4:0] pin_meta_r;
  logic [4:0] pin_sync_r;
  logic cts_s;
  logic dsr_s;
  logic dcd_s;
  logic rxd_s;
  logic sec_rxd_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_r <= 5'h18;
      pin_sync_r <= 5'h18;
    end else begin
      pin_meta_r <= {sec_rxd, rxd, dcd, dsr, cts}; // [RULE15]
      pin_sync_r <= pin_meta_r;
    end
  end

  assign cts_s = pin_sync_r[0]; // [RULE8]
  assign dsr_s = pin_sync_r[1]; // [RULE8]
  assign dcd_s = pin_sync_r[2]; // [RULE8]
  assign rxd_s = pin_sync_r[3];
  assign sec_rxd_s = pin_sync_r[4]; // [RULE12]

  logic [`MCH_CTRL_W-1:0] ctrl_r;
  logic [DIV_W-1:0] div_r;
  logic line_ctl;
  logic remote;
  logic busy;
  logic q_full;

  assign line_ctl = ctrl_r[`MCH_C_LINE_CTL];
  assign remote = ctrl_r[`MCH_C_REMOTE];
  assign sec_txd = ctrl_r[`MCH_C_SEC_TX]; // [RULE11]

  // Modem control outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts <= 1'b0;
    end else if (line_ctl) begin
      rts <= ctrl_r[`MCH_C_XMIT]; // [RULE2]
    end else begin
      rts <= 1'b1; // [RULE1]
    end
  end

  // Printer-ready option only applies outside line-control mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dtr <= 1'b0;
    end else if (!remote) begin
      dtr <= 1'b0;
    end else if (!line_ctl && ctrl_r[`MCH_C_PRDY_OPT] &&
                 (ctrl_r[`MCH_C_ERR] || ctrl_r[`MCH_C_NEAR_FULL])) begin
      dtr <= 1'b0; // [RULE7]
    end else begin
      dtr <= 1'b1; // [RULE6]
    end
  end

  // Transmit path: register writes fill the queue, the serialiser drains it
  mch_stream_if #(.W(7)) q_in ();
  mch_stream_if #(.W(7)) q_out ();

  mch_fifo #(.W(7), .DEPTH(QDEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .fill(q_in.snk),
    .drain(q_out.src),
    .full(q_full)
  );

  mch_uart_tx #(.DIV_W(DIV_W)) u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .bit_div(div_r),
    .odd_par(ctrl_r[`MCH_C_ODD]),
    .send_ok(cts_s), // [RULE3]
    .chr(q_out.snk),
    .txd(txd),
    .busy(busy)
  );

  // Receiver
  mch_rx_state_e rx_st_r;
  logic [DIV_W-1:0] rx_cnt_r;
  logic [3:0] rx_n_r;
  logic [7:0] rx_sh_r;
  logic rx_en;
  logic rx_done;
  logic rx_perr;
  mch_char_t rx_chr_r;
  logic rx_valid_r;
  logic perr_r;
  logic ovr_r;
  logic rx_pop;
  logic stat_clr_perr;
  logic stat_clr_ovr;

  assign rx_en = dcd_s && (dsr_s || !remote); // [RULE4] [RULE5]
  assign rx_done = (rx_st_r == MCH_RX_STOP) && (rx_cnt_r == '0) && rxd_s;
  assign rx_perr = ctrl_r[`MCH_C_PAR_EN] &&
                   (rx_sh_r[7] != (ctrl_r[`MCH_C_ODD] ? ~(^rx_sh_r[6:0]) : ^rx_sh_r[6:0])); // [RULE14]

  // Losing carrier, or data-set-ready in remote mode, mid-frame abandons the character
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_en) begin
      rx_st_r <= MCH_RX_IDLE;
      rx_cnt_r <= '0;
      rx_n_r <= '0;
      rx_sh_r <= '0;
    end else begin
      case (rx_st_r)
        MCH_RX_IDLE: begin
          if (!rxd_s) begin // [RULE10]
            rx_st_r <= MCH_RX_START;
            rx_cnt_r <= {1'b0, div_r[DIV_W-1:1]};
          end
        end
        MCH_RX_START: begin
          if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - 1'b1;
          end else if (!rxd_s) begin
            rx_st_r <= MCH_RX_BITS;
            rx_cnt_r <= div_r - 1'b1;
            rx_n_r <= 4'd8;
          end else begin
            rx_st_r <= MCH_RX_IDLE;
          end
        end
        MCH_RX_BITS: begin
          if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - 1'b1;
          end else begin
            rx_sh_r <= {rxd_s, rx_sh_r[7:1]}; // [RULE13]
            rx_cnt_r <= div_r - 1'b1;
            rx_n_r <= rx_n_r - 4'd1;
            if (rx_n_r == 4'd1) begin
              rx_st_r <= MCH_RX_STOP;
            end
          end
        end
        MCH_RX_STOP: begin
          if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - 1'b1;
          end else begin
            rx_st_r <= MCH_RX_IDLE;
          end
        end
        default: begin
          rx_st_r <= MCH_RX_IDLE;
        end
      endcase
    end
  end

  // A character with a bad stop bit is dropped without a flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_chr_r <= '0;
      rx_valid_r <= 1'b0;
    end else if (rx_done) begin
      rx_chr_r <= rx_sh_r[6:0];
      rx_valid_r <= 1'b1;
    end else if (rx_pop) begin
      rx_valid_r <= 1'b0;
    end
  end

  // Sticky flags: a new event outranks a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      perr_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      perr_r <= (rx_done && rx_perr) || (perr_r && !stat_clr_perr);
      ovr_r <= (rx_done && rx_valid_r && !rx_pop) || (ovr_r && !stat_clr_ovr);
    end
  end

  // AXI4-Lite write channel: address and data taken together
  logic [ADDR_W-1:0] waddr;
  logic wr_is_tx;
  logic wr_go;
  logic wr_hit;
  logic [31:0] wmask;

  assign waddr = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
  assign wr_is_tx = (waddr == ADDR_W'(`MCH_OFS_TXD));
  assign q_in.valid = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && wr_is_tx && s_axi_wstrb[0];
  assign q_in.data = s_axi_wdata[6:0];
  // A full queue holds off the write handshake, which stalls the master
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && (!q_in.valid || q_in.ready);
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign wr_hit = (waddr == ADDR_W'(`MCH_OFS_CTRL)) || (waddr == ADDR_W'(`MCH_OFS_STAT)) ||
                  wr_is_tx || (waddr == ADDR_W'(`MCH_OFS_BAUD)) || (waddr == ADDR_W'(`MCH_OFS_RXD));
  assign stat_clr_perr = wr_go && (waddr == ADDR_W'(`MCH_OFS_STAT)) && s_axi_wstrb[0] &&
                         s_axi_wdata[`MCH_S_PERR];
  assign stat_clr_ovr = wr_go && (waddr == ADDR_W'(`MCH_OFS_STAT)) && s_axi_wstrb[0] &&
                        s_axi_wdata[`MCH_S_OVR];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign wmask[gi*8 +: 8] = {8{s_axi_wstrb[gi]}};
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `MCH_CTRL_W'(`MCH_CTRL_RST);
    end else if (wr_go && waddr == ADDR_W'(`MCH_OFS_CTRL)) begin
      ctrl_r <= (ctrl_r & ~wmask[`MCH_CTRL_W-1:0]) | (s_axi_wdata[`MCH_CTRL_W-1:0] & wmask[`MCH_CTRL_W-1:0]);
    end
  end

  // A zero divisor would stall both serialisers, so it is refused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= BAUD_DIV;
    end else if (wr_go && waddr == ADDR_W'(`MCH_OFS_BAUD) &&
                 ((s_axi_wdata[DIV_W-1:0] & wmask[DIV_W-1:0]) | (div_r & ~wmask[DIV_W-1:0])) != '0) begin
      div_r <= (div_r & ~wmask[DIV_W-1:0]) | (s_axi_wdata[DIV_W-1:0] & wmask[DIV_W-1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MCH_RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `MCH_RESP_OK : `MCH_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read channel
  logic [ADDR_W-1:0] raddr;
  logic rd_go;
  mch_word_t stat_w;
  mch_word_t rd_w;
  logic rd_hit;

  assign raddr = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;
  assign rx_pop = rd_go && (raddr == ADDR_W'(`MCH_OFS_RXD));

  always_comb begin
    stat_w = '0;
    stat_w[`MCH_S_CTS] = cts_s;
    stat_w[`MCH_S_DSR] = dsr_s;
    stat_w[`MCH_S_DCD] = dcd_s;
    stat_w[`MCH_S_RTS] = rts;
    stat_w[`MCH_S_DTR] = dtr;
    stat_w[`MCH_S_RXV] = rx_valid_r;
    stat_w[`MCH_S_PERR] = perr_r;
    stat_w[`MCH_S_OVR] = ovr_r;
    stat_w[`MCH_S_SEC_RX] = sec_rxd_s; // [RULE12]
    stat_w[`MCH_S_TX_BUSY] = busy;
    stat_w[`MCH_S_Q_EMPTY] = !q_out.valid;
    stat_w[`MCH_S_Q_FULL] = q_full;
  end

  always_comb begin
    rd_w = '0;
    rd_hit = 1'b1;
    case (raddr)
      ADDR_W'(`MCH_OFS_CTRL): rd_w[`MCH_CTRL_W-1:0] = ctrl_r;
      ADDR_W'(`MCH_OFS_STAT): rd_w = stat_w;
      ADDR_W'(`MCH_OFS_TXD): rd_w = '0;
      ADDR_W'(`MCH_OFS_RXD): rd_w[`MCH_RXD_VALID:0] = {rx_valid_r, 1'b0, rx_chr_r};
      ADDR_W'(`MCH_OFS_BAUD): rd_w[DIV_W-1:0] = div_r;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `MCH_RESP_OK;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_w;
      s_axi_rresp <= rd_hit ? `MCH_RESP_OK : `MCH_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> test/mch_top_props.sv
// Concurrent checks on the modem port pins and its register bus
`timescale 1ns/1ps
`default_nettype none
`include "mch_regs.svh"
module mch_top_props #(
  parameter int ADDR_W = 8,
  parameter int BAUD_DIV = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire mch_pkg::mch_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic txd,
  input wire logic rts,
  input wire logic cts,
  input wire logic dtr,
  input wire logic sec_txd
);
  import mch_pkg::*;
  localparam int MID = BAUD_DIV / 2;
  localparam int STOP_REST = 9 * BAUD_DIV;
  localparam int IDLE_MIN = 10 * BAUD_DIV;
  logic wr_take;
  logic wr_bad;
  logic rts_exp;
  logic dtr_exp;
  logic [8:0] ctrl_r;
  logic [1:0] up_r;
  int hi_r;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign wr_bad = {s_axi_awaddr[ADDR_W-1:2], 2'b00} > ADDR_W'(`MCH_OFS_BAUD);
  assign rts_exp = ctrl_r[`MCH_C_LINE_CTL] ? ctrl_r[`MCH_C_XMIT] : 1'b1;
  assign dtr_exp = ctrl_r[`MCH_C_REMOTE] && !(!ctrl_r[`MCH_C_LINE_CTL] && ctrl_r[`MCH_C_PRDY_OPT]
                   && (ctrl_r[`MCH_C_ERR] || ctrl_r[`MCH_C_NEAR_FULL]));
  // Shadow of the control word, rebuilt from bus traffic so that pin levels can be predicted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `MCH_CTRL_RST;
    end else if (wr_take && s_axi_awaddr[ADDR_W-1:2] == '0) begin
      if (s_axi_wstrb[0]) ctrl_r[7:0] <= s_axi_wdata[7:0];
      if (s_axi_wstrb[1]) ctrl_r[8] <= s_axi_wdata[8];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  // Long mark run means the line is idle: no frame holds more than nine mark bits in a row
  always_ff @(posedge aclk) begin
    if (!aresetn || !txd) hi_r <= 0;
    else if (hi_r < IDLE_MIN) hi_r <= hi_r + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_cts_off;
    !cts [*8];
  endsequence
  sequence s_frame_tail;
    ##MID !txd ##STOP_REST txd;
  endsequence
  a_tx_cts_gate: assert property ((s_cts_off ##0 hi_r >= IDLE_MIN) |=> txd)
    else $error("character started while clear-to-send was off");
  a_frame_mark: assert property ((!txd && hi_r >= IDLE_MIN) |-> s_frame_tail)
    else $error("start bit or stop bit level wrong");
  a_rts_mode: assert property (up_r == 2'h3 |-> rts == $past(rts_exp))
    else $error("request-to-send level wrong");
  a_dtr_mode: assert property (up_r == 2'h3 |-> dtr == $past(dtr_exp))
    else $error("data-terminal-ready level wrong");
  a_sec_tx_level: assert property ($changed(ctrl_r[8]) |-> ##[0:1] (sec_txd == ctrl_r[8]))
    else $error("reverse channel level did not follow control");
  a_wr_answer: assert property (wr_take |=> s_axi_bvalid)
    else $error("write response late");
  a_wr_resp_code: assert property (wr_take |=> s_axi_bresp == $past(wr_bad ? `MCH_RESP_SLVERR : `MCH_RESP_OK))
    else $error("write response code wrong");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule
bind mch_top mch_top_props #(.ADDR_W(ADDR_W), .BAUD_DIV(int'(BAUD_DIV))) i_mch_top_props (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .txd, .rts, .cts, .dtr, .sec_txd);
`default_nettype wire

// >>> test/mch_modem_model.sv
// Modem on the far side: fail-safe control lines and a received-data sender
`timescale 1ns/1ps
`default_nettype none
module mch_modem_model #(
  parameter int BAUD_DIV = 16
) (
  input wire logic aclk,
  input wire logic powered,
  input wire logic cts_on,
  input wire logic dsr_on,
  input wire logic dcd_on,
  input wire logic sec_on,
  output logic cts,
  output logic dsr,
  output logic dcd,
  output var logic rxd,
  output logic sec_rxd
);
  // An unpowered modem or pulled cable reads as off on every control line
  assign cts = powered && cts_on;
  assign dsr = powered && dsr_on;
  assign dcd = powered && dcd_on;
  assign sec_rxd = powered && sec_on;
  initial rxd = 1'b1;
  task automatic send_char(input logic [6:0] c, input logic par);
    logic [9:0] f;
    f = {1'b1, par, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BAUD_DIV) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Register-level tests of the modem port against a modem model
`timescale 1ns/1ps
`default_nettype none
`include "mch_regs.svh"
module testbench;
  import mch_pkg::*;
  localparam int DIV = 16;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0;
  logic [2:0] s_axi_arprot = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  mch_word_t s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  mch_word_t s_axi_rdata, rd;
  logic txd, rxd, rts, cts, dsr, dtr, dcd, sec_txd, sec_rxd;
  logic powered = 1, cts_on = 1, dsr_on = 1, dcd_on = 1, sec_on = 0;
  int n_fail = 0;
  int n_compared = 0;
  logic [8:0] ctl_tab [7] = '{9'h101, 9'h103, 9'h11D, 9'h11C, 9'h12C, 9'h114, 9'h100};
  logic [1:0] pin_tab [7] = '{2'b00, 2'b10, 2'b01, 2'b10, 2'b10, 2'b11, 2'b10};
  logic [8:0] rx_ctl [6] = '{9'h104, 9'h104, 9'h104, 9'h100, 9'h144, 9'h104};
  logic [4:0] rx_tab [6] = '{5'b11010, 5'b10000, 5'b01000, 5'b01010, 5'b11111, 5'b11110};
  always #12.5 aclk = ~aclk;
  mch_top #(.BAUD_DIV(20'(DIV))) i_mch_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .txd, .rxd, .rts, .cts, .dsr, .dtr, .dcd, .sec_txd, .sec_rxd);
  mch_modem_model #(.BAUD_DIV(DIV)) i_mch_modem_model (.aclk, .powered, .cts_on, .dsr_on, .dcd_on, .sec_on,
    .cts, .dsr, .dcd, .rxd, .sec_rxd);
  task automatic chk_word(input string name, input mch_word_t exp, input mch_word_t got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_line(input string name, input logic exp, input logic got);
    chk_word(name, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic axi_write(input logic [7:0] a, input mch_word_t d, input logic [1:0] exp);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 2000);
    chk_line("write answer", 1'b1, s_axi_bvalid);
    chk_word("write response", {30'h0, exp}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [7:0] a, output mch_word_t d, input logic [1:0] exp);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 2000);
    chk_line("read answer", 1'b1, s_axi_rvalid);
    d = s_axi_rdata;
    chk_word("read response", {30'h0, exp}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Samples mid-bit and returns at mid stop bit, so a back-to-back start is not missed
  task automatic chk_frame(input logic [6:0] c, input logic odd);
    logic [9:0] f;
    int n = 0;
    while (txd !== 1'b0 && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    repeat (DIV / 2) @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd;
      if (i < 9) repeat (DIV) @(posedge aclk);
    end
    chk_word("tx frame", {22'h0, 1'b1, ^c ^ odd, c, 1'b0}, {22'h0, f});
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    n_fail++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    final_report();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_read(`MCH_OFS_CTRL, rd, `MCH_RESP_OK);
    chk_word("ctrl reset", 32'h104, rd);
    axi_read(`MCH_OFS_BAUD, rd, `MCH_RESP_OK);
    chk_word("baud reset", DIV, rd);
    chk_line("rts", 1'b1, rts);
    chk_line("dtr", 1'b1, dtr);
    chk_line("txd idle", 1'b1, txd);
    axi_read(8'h14, rd, `MCH_RESP_SLVERR);
    chk_word("unmapped read", 32'h0, rd);
    axi_write(8'h20, 32'h0, `MCH_RESP_SLVERR);
    axi_write(`MCH_OFS_BAUD, DIV, `MCH_RESP_OK);
    for (int i = 0; i < 7; i++) begin
      axi_write(`MCH_OFS_CTRL, {23'h0, ctl_tab[i]}, `MCH_RESP_OK);
      chk_line("rts", pin_tab[i][1], rts);
      chk_line("dtr", pin_tab[i][0], dtr);
    end
    axi_write(`MCH_OFS_CTRL, 32'h004, `MCH_RESP_OK);
    chk_line("sec txd", 1'b0, sec_txd);
    sec_on <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_read(`MCH_OFS_STAT, rd, `MCH_RESP_OK);
    chk_line("sec rxd", 1'b1, rd[`MCH_S_SEC_RX]);
    axi_write(`MCH_OFS_CTRL, 32'h104, `MCH_RESP_OK);
    chk_line("sec txd", 1'b1, sec_txd);
    powered <= 1'b0;
    repeat (4) @(posedge aclk);
    axi_read(`MCH_OFS_STAT, rd, `MCH_RESP_OK);
    chk_word("lines unpowered", 32'h0, {29'h0, rd[2:0]});
    powered <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_read(`MCH_OFS_STAT, rd, `MCH_RESP_OK);
    chk_word("lines powered", 32'h7, {29'h0, rd[2:0]});
    // Clear-to-send off stalls the serialiser, so the queue fills up
    cts_on <= 1'b0;
    repeat (4) @(posedge aclk);
    for (int i = 0; i < 16; i++) axi_write(`MCH_OFS_TXD, 32'h40 + i, `MCH_RESP_OK);
    axi_read(`MCH_OFS_STAT, rd, `MCH_RESP_OK);
    chk_line("queue full", 1'b1, rd[`MCH_S_Q_FULL]);
    chk_line("txd held", 1'b1, txd);
    cts_on <= 1'b1;
    for (int i = 0; i < 16; i++) chk_frame(7'h40 + 7'(i), 1'b0);
    axi_read(`MCH_OFS_STAT, rd, `MCH_RESP_OK);
    chk_line("queue empty", 1'b1, rd[`MCH_S_Q_EMPTY]);
    axi_write(`MCH_OFS_CTRL, 32'h184, `MCH_RESP_OK);
    axi_write(`MCH_OFS_TXD, 32'h55, `MCH_RESP_OK);
    chk_frame(7'h55, 1'b1);
    for (int i = 0; i < 6; i++) begin
      dsr_on <= rx_tab[i][4];
      dcd_on <= rx_tab[i][3];
      axi_write(`MCH_OFS_CTRL, {23'h0, rx_ctl[i]}, `MCH_RESP_OK);
      i_mch_modem_model.send_char(7'h31 + 7'(i), ^(7'h31 + 7'(i)) ^ rx_tab[i][2]);
      repeat (4) @(posedge aclk);
      axi_read(`MCH_OFS_STAT, rd, `MCH_RESP_OK);
      chk_line("parity error", rx_tab[i][0], rd[`MCH_S_PERR]);
      axi_read(`MCH_OFS_RXD, rd, `MCH_RESP_OK);
      chk_line("rx valid", rx_tab[i][1], rd[`MCH_RXD_VALID]);
      if (rx_tab[i][1]) chk_word("rx char", 32'h131 + i, rd[8:0]);
      axi_write(`MCH_OFS_STAT, 32'hC0, `MCH_RESP_OK);
    end
    // Two characters with no read between them must raise overrun, and a write of one clears it
    i_mch_modem_model.send_char(7'h41, 1'b0);
    i_mch_modem_model.send_char(7'h42, 1'b0);
    repeat (4) @(posedge aclk);
    axi_read(`MCH_OFS_STAT, rd, `MCH_RESP_OK);
    chk_line("overrun", 1'b1, rd[`MCH_S_OVR]);
    axi_write(`MCH_OFS_STAT, 32'hC0, `MCH_RESP_OK);
    axi_read(`MCH_OFS_STAT, rd, `MCH_RESP_OK);
    chk_line("overrun cleared", 1'b0, rd[`MCH_S_OVR]);
    final_report();
  end
endmodule
`default_nettype wire
